// >>> pmsc_top.sv
// register logic for supply supervision and power-down control
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`include "pmsc_defines.svh"
module pmsc_top (
  // apb
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // reset cause, sampled while presetn low
  input  wire logic               power_on_reset,
  // comparators and power controller
  input  wire pmsc_pkg::pmsc_analog_s analog_in,
  // controls out
  output logic                    supply_detect_irq,
  output logic                    supply_detect_sys_reset,
  output logic                    supply_detect_active,
  output logic                    detect_threshold_select,
  output logic                    warning_threshold_select,
  output logic                    power_down_enable,
  output logic                    power_down_mode_select
);
  pmsc_pkg::pmsc_state_s  st_reg;
  pmsc_pkg::pmsc_state_s  st_next;
  pmsc_pkg::pmsc_analog_s an_sync;
  logic                   por_meta_reg;
  logic                   por_sync_reg;
  logic                   por_seen_reg;
  localparam logic [7:0]  LVDC_RST = `PMSC_LVDC_RESET;

  pmsc_sync #(.WIDTH(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (analog_in),
    .q       (an_sync)
  );

  // no reset on these flops, so the cause is still seen at release
  always_ff @(posedge pclk)
  begin
    por_meta_reg <= power_on_reset;
    por_sync_reg <= por_meta_reg;
    por_seen_reg <= por_sync_reg;
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  logic wr_en;
  logic rd_en;
  logic lane0;
  logic [7:0] wb;
  logic det_live;
  logic first_cycle_reg;
  logic sel_det_keep_reg;
  logic sel_warn_keep_reg;

  assign wr_en = psel && penable && pwrite && !st_reg.pready;
  assign rd_en = psel && penable && !pwrite && !st_reg.pready;
  assign lane0 = pstrb[0];
  assign wb    = pwdata[7:0];
  // detection runs when enabled, and in stop only with stop enable
  assign det_live = st_reg.detect_en && (!an_sync.in_stop || st_reg.stop_en);

  // selects kept across non power-on resets live outside async reset
  always_ff @(posedge pclk)
  begin
    // frozen while reset holds the register file cleared
    if (presetn)
    begin
      sel_det_keep_reg  <= st_reg.detect_sel;
      sel_warn_keep_reg <= st_reg.warning_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_cycle_reg <= 1'b1;
    else
      first_cycle_reg <= 1'b0;
  end

  always_comb
  begin
    st_next         = st_reg;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    // restore or clear the selects after reset release
    if (first_cycle_reg)
    begin
      st_next.detect_sel  = por_seen_reg ? 1'b0 : sel_det_keep_reg;
      st_next.warning_sel = por_seen_reg ? 1'b0 : sel_warn_keep_reg;
    end
    if (wr_en || rd_en)
    begin
      st_next.pready = 1'b1;
      st_next.pslverr = !(hit(paddr, `PMSC_ADDR_LVDC) || hit(paddr, `PMSC_ADDR_WPDC)
                          || hit(paddr, `PMSC_ADDR_STAT));
    end
    if (wr_en && lane0 && hit(paddr, `PMSC_ADDR_LVDC))
    begin
      if (wb[`PMSC_BIT_ACK])
        st_next.detect_flag = 1'b0;
      if (!st_reg.lvdc_written)
      begin
        st_next.lvdc_written = 1'b1;
        st_next.irq_en    = wb[`PMSC_BIT_IE];
        st_next.reset_en  = wb[`PMSC_BIT_RE];
        st_next.stop_en   = wb[`PMSC_BIT_SE];
        st_next.detect_en = wb[`PMSC_BIT_DE];
      end
    end
    if (wr_en && lane0 && hit(paddr, `PMSC_ADDR_WPDC))
    begin
      st_next.detect_sel  = wb[`PMSC_BIT_DV];
      st_next.warning_sel = wb[`PMSC_BIT_WV];
      if (wb[`PMSC_BIT_ACK] && !an_sync.warning_raw)
        st_next.warning_flag = 1'b0;
      if (wb[`PMSC_BIT_RACK])
        st_next.recovery_flag = 1'b0;
      if (!st_reg.wpdc_written)
      begin
        st_next.wpdc_written = 1'b1;
        st_next.pd_enable = wb[`PMSC_BIT_PDC];
        st_next.pd_mode   = wb[`PMSC_BIT_PDM];
      end
    end
    // hardware sets win over acknowledge in the same cycle
    if (det_live && an_sync.detect_raw)
      st_next.detect_flag = 1'b1;
    st_next.prev_warn = an_sync.warning_raw;
    // level-sensitive so a supply already low at reset also sets it
    if (an_sync.warning_raw)
      st_next.warning_flag = 1'b1;
    if (an_sync.partial_exit)
      st_next.recovery_flag = 1'b1;
    st_next.irq = st_next.detect_flag && st_next.irq_en;
    st_next.sys_reset = st_next.detect_flag && st_next.reset_en
                        && st_next.detect_en;
    st_next.prdata = 8'h00;
    if (rd_en)
    begin
      if (hit(paddr, `PMSC_ADDR_LVDC))
        st_next.prdata = {st_reg.detect_flag, 1'b0, st_reg.irq_en, st_reg.reset_en,
                          st_reg.stop_en, st_reg.detect_en, 2'b00};
      else if (hit(paddr, `PMSC_ADDR_WPDC))
        st_next.prdata = {st_reg.warning_flag, 1'b0, st_reg.detect_sel,
                          st_reg.warning_sel, st_reg.recovery_flag, 1'b0,
                          st_reg.pd_enable, st_reg.pd_mode};
      else if (hit(paddr, `PMSC_ADDR_STAT))
        st_next.prdata = {4'h0, st_reg.wpdc_written, st_reg.lvdc_written,
                          det_live, an_sync.warning_raw};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg           <= '0;
      st_reg.detect_en <= LVDC_RST[`PMSC_BIT_DE];
      st_reg.stop_en   <= LVDC_RST[`PMSC_BIT_SE];
      st_reg.reset_en  <= LVDC_RST[`PMSC_BIT_RE];
    end
    else
      st_reg <= st_next;
  end

  // detection status out; held a cycle behind the flops feeding it
  logic det_live_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      det_live_reg <= 1'b0;
    else
      det_live_reg <= det_live;
  end

  assign prdata                   = {24'h000000, st_reg.prdata};
  assign pready                   = st_reg.pready;
  assign pslverr                  = st_reg.pslverr;
  assign supply_detect_irq        = st_reg.irq;
  assign supply_detect_sys_reset  = st_reg.sys_reset;
  assign supply_detect_active     = det_live_reg;
  assign detect_threshold_select  = st_reg.detect_sel;
  assign warning_threshold_select = st_reg.warning_sel;
  assign power_down_enable        = st_reg.pd_enable;
  assign power_down_mode_select   = st_reg.pd_mode;
endmodule

// >>> pmsc_defines.svh
// constants for the power management status and control block
// Summary of operation
// - detect event sets detect flag when enabled
// - writing one to bit 6 clears detect flag
// - irq enable requests interrupt while flag set
// - reset enable forces system reset on flag
// - stop enable keeps detection alive in stop
// - detect enable gates detection and the system reset
// - write-once field takes first write only
// - warning flag sets on low supply, also after reset
// - warning ack clears flag only when condition gone
// - bit 5 selects detect threshold high or low
// - bit 4 selects warning threshold high or low
// - power-on clears all but the DE, SE and RE enables; other resets keep selects
// - recovery flag sets on partial power-down exit
// - writing one to bit 2 clears recovery flag
// - bit 1 enables power-down stop modes
// - bit 0 picks full or partial power-down
`ifndef PMSC_DEFINES_SVH
`define PMSC_DEFINES_SVH
`define PMSC_ADDR_LVDC    12'h000
`define PMSC_ADDR_WPDC    12'h004
`define PMSC_ADDR_STAT    12'h008
`define PMSC_BIT_FLAG     7
`define PMSC_BIT_ACK      6
`define PMSC_BIT_IE       5
`define PMSC_BIT_RE       4
`define PMSC_BIT_SE       3
`define PMSC_BIT_DE       2
`define PMSC_BIT_DV       5
`define PMSC_BIT_WV       4
`define PMSC_BIT_RF       3
`define PMSC_BIT_RACK     2
`define PMSC_BIT_PDC      1
`define PMSC_BIT_PDM      0
`define PMSC_LVDC_RESET   8'h1C
`endif

// >>> pmsc_pkg.sv
// types for the power management status and control block
package pmsc_pkg;
  typedef struct packed {
    logic       detect_en;
    logic       stop_en;
    logic       reset_en;
    logic       irq_en;
    logic       detect_flag;
    logic       lvdc_written;
    logic       warning_flag;
    logic       detect_sel;
    logic       warning_sel;
    logic       recovery_flag;
    logic       pd_enable;
    logic       pd_mode;
    logic       wpdc_written;
    logic       prev_warn;
    logic       irq;
    logic       sys_reset;
    logic       pready;
    logic       pslverr;
    logic [7:0] prdata;
  } pmsc_state_s;
  typedef struct packed {
    logic detect_raw;
    logic warning_raw;
    logic partial_exit;
    logic in_stop;
  } pmsc_analog_s;
endpackage

// >>> pmsc_sync.sv
// two flop synchroniser for the analog and power inputs
`timescale 1ns/100ps
module pmsc_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// >>> pmsc_top_assertions.sv
// port assertions for the power management block
`timescale 1ns/100ps
module pmsc_chk (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // selects
  input wire logic        detect_threshold_select,
  input wire logic        warning_threshold_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_take: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after take");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 12'h008))
    else $error("wrong error response");
  a_ack_reads_zero: assert property (
    pready && !pwrite |-> !prdata[6] && (paddr != 12'h004 || !prdata[2]))
    else $error("ack bit read as one");
  // pwdata is held one edge past the take, so $past still sees it
  a_dsel_write: assert property (
    psel && penable && !pready && pwrite && pstrb[0] && paddr == 12'h004
    |=> ##[0:1] detect_threshold_select == $past(pwdata[5]))
    else $error("detect select not written");
  a_wsel_write: assert property (
    psel && penable && !pready && pwrite && pstrb[0] && paddr == 12'h004
    |=> ##[0:1] warning_threshold_select == $past(pwdata[4]))
    else $error("warning select not written");
endmodule

// >>> pmsc_top_bench.sv
// self-checking bench for the power management block
`timescale 1ns/100ps
module pmsc_top_bench;
  localparam logic [11:0] L = 12'h000;
  localparam logic [11:0] W = 12'h004;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  logic        por = 1'b1;
  logic        irq, srst, act, dsel, wsel, pde, pdm;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  pmsc_pkg::pmsc_analog_s an = 4'h0;
  pmsc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .power_on_reset(por),
    .analog_in(an), .supply_detect_irq(irq), .supply_detect_sys_reset(srst),
    .supply_detect_active(act), .detect_threshold_select(dsel),
    .warning_threshold_select(wsel), .power_down_enable(pde),
    .power_down_mode_select(pdm));
  initial forever #25 pclk = ~pclk;
  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // a gap cycle before setup keeps psel from two writes in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask
  task automatic rst(input logic p);
    por <= p;
    presetn <= 1'b0;
    wt(20);
    presetn <= 1'b1;
    wt(2);
    por <= 1'b0;
  endtask
  // inputs pass a two-flop synchroniser, so hold them several cycles
  task automatic pulse(input int b);
    an[b] <= 1'b1;
    wt(6);
    an[b] <= 1'b0;
    wt(6);
  endtask
  initial
  begin
    rst(1'b1);
    rchk(L, 8'h1C);
    rchk(W, 8'h00);
    xfer(1'b1, L, 8'h2C);
    rchk(L, 8'h2C);
    xfer(1'b1, L, 8'h30);
    rchk(L, 8'h2C);
    an.in_stop <= 1'b1;
    pulse(3);
    rchk(L, 8'hAC);
    chk({irq, srst, act}, 3'h5);
    xfer(1'b1, L, 8'h6C);
    wt(3);
    chk(irq, 1'b0);
    rchk(L, 8'h2C);
    an.warning_raw <= 1'b1;
    wt(6);
    rchk(W, 8'h80);
    xfer(1'b1, W, 8'h43);
    rchk(W, 8'h83);
    an.warning_raw <= 1'b0;
    wt(6);
    xfer(1'b1, W, 8'h73);
    rchk(W, 8'h33);
    wt(2);
    chk({dsel, wsel, pde, pdm}, 4'hF);
    xfer(1'b1, W, 8'h00);
    rchk(W, 8'h03);
    xfer(1'b1, W, 8'h30);
    pulse(1);
    rchk(W, 8'h3B);
    xfer(1'b1, W, 8'h34);
    rchk(W, 8'h33);
    rst(1'b0);
    rchk(W, 8'h30);
    xfer(1'b1, L, 8'h14);
    wt(3);
    chk(act, 1'b0);
    an.in_stop <= 1'b0;
    pulse(3);
    chk({srst, irq}, 2'h2);
    rst(1'b1);
    rchk(W, 8'h00);
    xfer(1'b0, 12'h00C, 8'h00);
    chk(er, 1'b1);
    wrap_up;
  end
endmodule
bind pmsc_top pmsc_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .detect_threshold_select, .warning_threshold_select);
